//--- verilog/dio_params.svh
// register offsets, field positions and reset values of the digital i/o block
`ifndef DIO_PARAMS_SVH
`define DIO_PARAMS_SVH
`define DIO_ADR_DIR 8'h00
`define DIO_ADR_POL 8'h04
`define DIO_ADR_DATA 8'h08
`define DIO_ADR_MASK 8'h0C
`define DIO_ADR_ALL 8'h10
`define DIO_ADR_PWM_CTRL 8'h14
`define DIO_ADR_PWM_FIRST 8'h18
`define DIO_ADR_PWM_SECOND 8'h1C
`define DIO_ADR_PIN 8'h20
`define DIO_MASK_ON_LSB 0
`define DIO_MASK_OFF_LSB 8
`define DIO_PORT_SEL_LSB 16
`define DIO_ALL_PORT_LSB 0
`define DIO_ALL_VAL_BIT 8
`define DIO_CTRL_EN_FIRST 0
`define DIO_CTRL_EN_SECOND 1
`define DIO_CTRL_EXT_CLK 2
`define DIO_PWM_DUTY_LSB 16
`define DIO_RST_DIR 32'h0000_0000
`define DIO_RST_POL 32'h0000_0000
`define DIO_RST_OUT 32'h0000_0000
`define DIO_RST_PWM 32'h0000_0000
`endif

//--- verilog/dio_pkg.sv
// types shared by the digital i/o block and its pulse generators
package dio_pkg;
    typedef enum logic {DIO_CLK_INT, DIO_CLK_EXT} dio_clk_src_type;
    typedef struct packed {
        logic enable;
        logic [15:0] duty;
        logic [15:0] period;
    } dio_pwm_cfg_type;
endpackage

//--- verilog/dio_pwm_gen.sv
// one pulse width generator: counter modulo period, high below duty
`timescale 1ns/1ps
module dio_pwm_gen
    import dio_pkg::*;
#(
    parameter int CW = 16
)
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic tick,
    input wire dio_pwm_cfg_type cfg,
    output logic pulse
);
    if (CW < 1 || CW > 16)
    begin : g_chk
        $error("dio_pwm_gen: CW must be 1..16");
    end

    logic [CW-1:0] cnt;
    logic [CW-1:0] per;
    logic [CW-1:0] dty;
    logic active;

    assign per = cfg.period[CW-1:0];
    assign dty = cfg.duty[CW-1:0];
    // zero period would wrap only at the full count of the counter, so it parks the output low
    assign active = cfg.enable && (per != '0);

    always_ff @(posedge ref_clk)
    begin
        if (rst)
            cnt <= '0;
        else if (ce)
        begin
            if (!active)
                cnt <= '0;
            else if (tick)
            begin
                // >= also recovers when period shrinks below count
                if (cnt >= per - 1'b1)
                    cnt <= '0;
                else
                    cnt <= cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
            pulse <= 1'b0;
        else if (ce)
            pulse <= active && (cnt < dty);
    end

    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);

    property p_pwm_level;
        ce && active |=> pulse == $past(cnt < dty);
    endproperty
    a_pwm_level: assert property (p_pwm_level)
        else $error("pwm level does not follow count against duty");

    property p_pwm_wrap;
        ce && active && tick && cnt >= per - 1'b1 |=> cnt == '0;
    endproperty
    a_pwm_wrap: assert property (p_pwm_wrap)
        else $error("pwm counter did not wrap at period");

    property p_pwm_idle;
        ce && !active |=> !pulse && cnt == '0;
    endproperty
    a_pwm_idle: assert property (p_pwm_idle)
        else $error("disabled pwm output not idle");

    c_pwm_rise: cover property (active ##1 $rose(pulse));
endmodule

//--- verilog/dio_port_pwm.sv
// 32-line digital i/o with polarity, mask updates and two pwm outputs
//
// Decided for this implementation: the Wishbone slave port and the register offsets.
`timescale 1ns/1ps
`include "dio_params.svh"
// What this block does
// - 32 lines grouped as four byte ports
// - byte-wide commands, one bit per line
// - direction programmable per line
// - polarity per line, high or low active
// - logical values mapped to pin by polarity
// - input read returns polarity-corrected pin value
// - writes to input bits change nothing
// - writes to output bits set driven level
// - output read returns last written level
// - force-on and force-off masks, others kept
// - output lines of a port set or cleared any time
// - two pwm outputs, own period and duty
// - duty proportional to commanded value
// - pwm clock from external pin if selected
module dio_port_pwm
    import dio_pkg::*;
#(
    parameter int PWM_BITS = 16
)
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [31:0] dio_in,
    output logic [31:0] dio_out,
    output logic [31:0] dio_oe_n,
    input wire logic pclk_pin,
    output logic pulse_out_first,
    output logic pulse_out_second
);
    if (PWM_BITS < 1 || PWM_BITS > 16)
    begin : g_chk
        $error("dio_port_pwm: PWM_BITS must be 1..16");
    end

    logic [31:0] in_meta;
    logic [31:0] in_sync;
    logic pclk_meta;
    logic pclk_sync;
    logic pclk_last;
    logic [31:0] dir;
    logic [31:0] pol;
    logic [31:0] out_logic;
    logic [2:0] pwm_ctrl;
    logic [31:0] pwm_first;
    logic [31:0] pwm_second;
    logic [31:0] in_logic;
    logic [31:0] read_val;
    logic [31:0] next_read;
    logic wr;
    logic [1:0] mask_port;
    logic [1:0] all_port;
    logic [7:0] on_mask;
    logic [7:0] off_mask;
    logic [7:0] dir_byte;
    logic [7:0] all_dir_byte;
    logic tick;
    dio_clk_src_type clk_src;
    dio_pwm_cfg_type cfg_first;
    dio_pwm_cfg_type cfg_second;

    // merge new data into old by wishbone byte lanes
    function automatic logic [31:0] lane_merge(
        input logic [31:0] old_val,
        input logic [31:0] new_val,
        input logic [3:0] sel
    );
        logic [31:0] res;
        res = old_val;
        for (int i = 0; i < 4; i++)
        begin
            if (sel[i])
                res[i*8 +: 8] = new_val[i*8 +: 8];
        end
        return res;
    endfunction

    // output bits take the new value, input bits keep the old one
    function automatic logic [31:0] out_only(
        input logic [31:0] old_val,
        input logic [31:0] new_val,
        input logic [31:0] dmask
    );
        return (new_val & dmask) | (old_val & ~dmask);
    endfunction

    // pins are asynchronous to ref_clk
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            in_meta <= 32'h0000_0000;
            in_sync <= 32'h0000_0000;
        end
        else if (ce)
        begin
            in_meta <= dio_in;
            in_sync <= in_meta;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            pclk_meta <= 1'b0;
            pclk_sync <= 1'b0;
            pclk_last <= 1'b0;
        end
        else if (ce)
        begin
            pclk_meta <= pclk_pin;
            pclk_sync <= pclk_meta;
            pclk_last <= pclk_sync;
        end
    end

    // external clock only counts rising edges slower than ref_clk / 2
    assign clk_src = pwm_ctrl[`DIO_CTRL_EXT_CLK] ? DIO_CLK_EXT : DIO_CLK_INT;
    assign tick = (clk_src == DIO_CLK_EXT) ?
        (pclk_sync & ~pclk_last) : 1'b1;

    assign wr = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;
    assign mask_port = wb_dat_i[`DIO_PORT_SEL_LSB +: 2];
    assign all_port = wb_dat_i[`DIO_ALL_PORT_LSB +: 2];
    assign on_mask = wb_dat_i[`DIO_MASK_ON_LSB +: 8];
    assign off_mask = wb_dat_i[`DIO_MASK_OFF_LSB +: 8];
    assign dir_byte = dir[{mask_port, 3'b000} +: 8];
    assign all_dir_byte = dir[{all_port, 3'b000} +: 8];

    // wishbone classic: ack one cycle after strobe, state updates on ack
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            wb_ack_o <= 1'b0;
        else if (ce)
            wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            dir <= `DIO_RST_DIR;
            pol <= `DIO_RST_POL;
        end
        else if (ce && wr)
        begin
            if (wb_adr_i == `DIO_ADR_DIR)
                dir <= lane_merge(dir, wb_dat_i, wb_sel_i);
            if (wb_adr_i == `DIO_ADR_POL)
                pol <= lane_merge(pol, wb_dat_i, wb_sel_i);
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
            out_logic <= `DIO_RST_OUT;
        else if (ce && wr)
        begin
            case (wb_adr_i)
                `DIO_ADR_DATA:
                    out_logic <= lane_merge(out_logic,
                        out_only(out_logic, wb_dat_i, dir),
                        wb_sel_i);
                `DIO_ADR_MASK:
                    // force-on wins where both masks name a bit
                    out_logic[{mask_port, 3'b000} +: 8] <=
                        (out_logic[{mask_port, 3'b000} +: 8]
                        & ~(off_mask & dir_byte))
                        | (on_mask & dir_byte);
                `DIO_ADR_ALL:
                    out_logic[{all_port, 3'b000} +: 8] <=
                        (out_logic[{all_port, 3'b000} +: 8] & ~all_dir_byte)
                        | ({8{wb_dat_i[`DIO_ALL_VAL_BIT]}}
                        & all_dir_byte);
                default:
                    out_logic <= out_logic;
            endcase
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            pwm_ctrl <= 3'h0;
            pwm_first <= `DIO_RST_PWM;
            pwm_second <= `DIO_RST_PWM;
        end
        else if (ce && wr)
        begin
            if (wb_adr_i == `DIO_ADR_PWM_CTRL && wb_sel_i[0])
                pwm_ctrl <= wb_dat_i[2:0];
            if (wb_adr_i == `DIO_ADR_PWM_FIRST)
                pwm_first <= lane_merge(pwm_first, wb_dat_i, wb_sel_i);
            if (wb_adr_i == `DIO_ADR_PWM_SECOND)
                pwm_second <= lane_merge(pwm_second, wb_dat_i, wb_sel_i);
        end
    end

    assign in_logic = in_sync ^ pol;
    assign read_val = (out_logic & dir) | (in_logic & ~dir);

    always_comb
    begin
        case (wb_adr_i)
            `DIO_ADR_DIR: next_read = dir;
            `DIO_ADR_POL: next_read = pol;
            `DIO_ADR_DATA: next_read = read_val;
            `DIO_ADR_PWM_CTRL: next_read = {29'h0000_0000, pwm_ctrl};
            `DIO_ADR_PWM_FIRST: next_read = pwm_first;
            `DIO_ADR_PWM_SECOND: next_read = pwm_second;
            `DIO_ADR_PIN: next_read = in_sync;
            default: next_read = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
            wb_dat_o <= 32'h0000_0000;
        else if (ce)
            wb_dat_o <= (wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_we_i) ?
                next_read : 32'h0000_0000;
    end

    // pins follow register state one cycle late, as plain flops
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            dio_out <= 32'h0000_0000;
            dio_oe_n <= 32'hFFFF_FFFF;
        end
        else if (ce)
        begin
            dio_out <= out_logic ^ pol;
            dio_oe_n <= ~dir;
        end
    end

    assign cfg_first = '{enable: pwm_ctrl[`DIO_CTRL_EN_FIRST],
        duty: pwm_first[`DIO_PWM_DUTY_LSB +: 16],
        period: pwm_first[15:0]};
    assign cfg_second = '{enable: pwm_ctrl[`DIO_CTRL_EN_SECOND],
        duty: pwm_second[`DIO_PWM_DUTY_LSB +: 16],
        period: pwm_second[15:0]};

    dio_pwm_gen #(
        .CW(PWM_BITS)
    ) u_pwm_first (
        .ref_clk(ref_clk),
        .rst(rst),
        .ce(ce),
        .tick(tick),
        .cfg(cfg_first),
        .pulse(pulse_out_first)
    );

    dio_pwm_gen #(
        .CW(PWM_BITS)
    ) u_pwm_second (
        .ref_clk(ref_clk),
        .rst(rst),
        .ce(ce),
        .tick(tick),
        .cfg(cfg_second),
        .pulse(pulse_out_second)
    );

    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);

    property p_ack_pulse;
        ce && wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse)
        else $error("ack held longer than one cycle");

    property p_in_ignored;
        ce |=> ((out_logic ^ $past(out_logic)) & ~$past(dir)) == 0;
    endproperty
    a_in_ignored: assert property (p_in_ignored)
        else $error("stored level of an input bit changed");

    property p_out_write;
        ce && wr && wb_adr_i == `DIO_ADR_DATA && wb_sel_i == 4'hF
        |=> ((out_logic ^ $past(wb_dat_i)) & $past(dir)) == 0;
    endproperty
    a_out_write: assert property (p_out_write)
        else $error("output bit did not take written value");

    property p_pin_level;
        ce |=> dio_out == $past(out_logic ^ pol);
    endproperty
    a_pin_level: assert property (p_pin_level)
        else $error("pin level does not match logic and polarity");

    property p_dir_oe;
        ce |=> dio_oe_n == ~$past(dir);
    endproperty
    a_dir_oe: assert property (p_dir_oe)
        else $error("output enable does not follow direction");

    property p_read_out;
        wb_ack_o && !wb_we_i && wb_adr_i == `DIO_ADR_DATA && $past(ce)
        |-> ((wb_dat_o ^ $past(out_logic)) & $past(dir)) == 0;
    endproperty
    a_read_out: assert property (p_read_out)
        else $error("output bit read is not last written level");

    property p_read_in;
        wb_ack_o && !wb_we_i && wb_adr_i == `DIO_ADR_DATA && $past(ce)
        |-> ((wb_dat_o ^ $past(in_sync ^ pol)) & ~$past(dir)) == 0;
    endproperty
    a_read_in: assert property (p_read_in)
        else $error("input bit read is not pin after polarity");

    property p_mask;
        ce && wr && wb_adr_i == `DIO_ADR_MASK && mask_port == 2'd0
        |=> (out_logic[7:0] & $past(on_mask & dir[7:0]))
            == $past(on_mask & dir[7:0])
            && out_logic[31:8] == $past(out_logic[31:8]);
    endproperty
    a_mask: assert property (p_mask)
        else $error("mask update wrong or touched other ports");

    property p_all;
        ce && wr && wb_adr_i == `DIO_ADR_ALL && all_port == 2'd1
        && !wb_dat_i[`DIO_ALL_VAL_BIT]
        |=> (out_logic[15:8] & $past(dir[15:8])) == 8'h00;
    endproperty
    a_all: assert property (p_all)
        else $error("whole port clear left an output bit set");

    c_mask_write: cover property (wr && wb_adr_i == `DIO_ADR_MASK);
    c_read_data: cover property (wb_ack_o && !wb_we_i
        && wb_adr_i == `DIO_ADR_DATA);
    c_ext_tick: cover property (clk_src == DIO_CLK_EXT && tick);
endmodule

//--- tb/dio_pins_model.sv
// sensors, loads and external pwm clock source on the i/o pins
`timescale 1ns/1ps
module dio_pins_model
(
    input wire logic ref_clk,
    input wire logic [31:0] dio_out,
    input wire logic [31:0] dio_oe_n,
    input wire logic [31:0] sense,
    input wire logic pclk_run,
    output logic [31:0] dio_in,
    output logic pclk_pin
);
    logic [1:0] div;
    // a driven line reads back its own drive, others see the sensor
    assign dio_in = (sense & dio_oe_n) | (dio_out & ~dio_oe_n);
    initial
    begin
        div = 2'd0;
        pclk_pin = 1'b0;
    end
    // stands low when unused; eight ref cycles a period, exact counts
    always @(posedge ref_clk)
    begin
        if (!pclk_run)
        begin
            div <= 2'd0;
            pclk_pin <= 1'b0;
        end
        else
        begin
            div <= div + 2'd1;
            if (div == 2'd3)
                pclk_pin <= ~pclk_pin;
        end
    end
endmodule

//--- tb/dio_port_pwm_tb.sv
// self-checking bench of the digital i/o block
`timescale 1ns/1ps
`include "dio_params.svh"
module dio_port_pwm_tb;
    logic ref_clk, rst, ce, wb_cyc_i, wb_stb_i, wb_we_i, pclk_pin, pclk_run;
    logic [7:0] wb_adr_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, dio_in, dio_out, dio_oe_n, sense;
    logic wb_ack_o, pulse_out_first, pulse_out_second;
    logic [31:0] lg, dir, pol, held;
    int failures, n_compared, n_hi;

    dio_port_pwm dio_port_pwm_i (.ref_clk(ref_clk), .rst(rst), .ce(ce),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .dio_in(dio_in),
        .dio_out(dio_out), .dio_oe_n(dio_oe_n), .pclk_pin(pclk_pin),
        .pulse_out_first(pulse_out_first),
        .pulse_out_second(pulse_out_second));
    dio_pins_model dio_pins_model_i (.ref_clk(ref_clk), .dio_out(dio_out),
        .dio_oe_n(dio_oe_n), .sense(sense), .pclk_run(pclk_run),
        .dio_in(dio_in), .pclk_pin(pclk_pin));

    task automatic summarize();
        if (failures == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
        input string what);
        n_compared++;
        if (got !== exp)
        begin
            failures++;
            $display("wrong value at %0t: %s got %h exp %h", $time, what,
                got, exp);
        end
    endtask

    task automatic wb_cycle(input logic w, input logic [7:0] a,
        input logic [31:0] d, input logic [3:0] s, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge ref_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= s;
        do
        begin
            @(posedge ref_clk);
            n++;
        end
        while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        // ack is seen at the second edge after the request goes up
        chk(32'(n), 32'd2, "ack latency");
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d,
        input logic [3:0] s);
        logic [31:0] q;
        wb_cycle(1'b1, a, d, s, q);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        wb_cycle(1'b0, a, 32'h0000_0000, 4'hF, q);
        chk(q, e, "read data");
    endtask

    // logic readback, pin drive and enables against the tracked state
    task automatic check_data();
        rd_chk(`DIO_ADR_DATA, (lg & dir) | ((sense ^ pol) & ~dir));
        chk(dio_out, lg ^ pol, "pin drive");
        chk(dio_oe_n, ~dir, "pin enable");
    endtask

    task automatic mask(input logic [1:0] p, input logic [7:0] on,
        input logic [7:0] off);
        logic [31:0] m;
        m = (32'h0000_00FF << (8 * p)) & dir;
        wr(`DIO_ADR_MASK, {14'h0, p, off, on}, 4'hF);
        // force-on applied last so it wins over force-off
        lg = (lg & ~({4{off}} & m)) | ({4{on}} & m);
    endtask

    task automatic set_all(input logic [1:0] p, input logic v);
        logic [31:0] m;
        m = (32'h0000_00FF << (8 * p)) & dir;
        wr(`DIO_ADR_ALL, {23'h0, v, 6'h0, p}, 4'hF);
        lg = v ? (lg | m) : (lg & ~m);
    endtask

    function automatic int hi(int d, int p, int n, int tk);
        if (p == 0 || d == 0)
            return 0;
        if (d >= p)
            return n;
        return n / (p * tk) * d * tk;
    endfunction

    // window is a whole number of periods, so the high count is exact
    task automatic pwm(input int d1, input int p1, input int d2,
        input int p2, input logic ext, input logic [1:0] en);
        int c1, c2, tk;
        c1 = 0;
        c2 = 0;
        tk = ext ? 8 : 1;
        wr(`DIO_ADR_PWM_FIRST, {16'(d1), 16'(p1)}, 4'hF);
        wr(`DIO_ADR_PWM_SECOND, {16'(d2), 16'(p2)}, 4'hF);
        wr(`DIO_ADR_PWM_CTRL, {29'h0, ext, en}, 4'h1);
        pclk_run <= ext;
        repeat (60) @(posedge ref_clk);
        repeat (160)
        begin
            @(posedge ref_clk);
            c1 += (pulse_out_first === 1'b1);
            c2 += (pulse_out_second === 1'b1);
        end
        chk(32'(c1), 32'(hi(en[0] ? d1 : 0, p1, 160, tk)), "first highs");
        chk(32'(c2), 32'(hi(en[1] ? d2 : 0, p2, 160, tk)), "second highs");
    endtask

    initial
    begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    initial
    begin
        repeat (20000) @(posedge ref_clk);
        failures++;
        summarize();
    end

    initial
    begin
        rst = 1'b1;
        ce = 1'b1;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i = 1'b0;
        wb_adr_i = 8'h00;
        wb_sel_i = 4'h0;
        wb_dat_i = 32'h0000_0000;
        sense = 32'h1234_5678;
        pclk_run = 1'b0;
        failures = 0;
        n_compared = 0;
        lg = 32'h0000_0000;
        dir = 32'h0000_0000;
        pol = 32'h0000_0000;
        repeat (12) @(posedge ref_clk);
        rst <= 1'b0;
        rd_chk(`DIO_ADR_DIR, `DIO_RST_DIR);
        rd_chk(`DIO_ADR_POL, `DIO_RST_POL);
        rd_chk(`DIO_ADR_PWM_CTRL, 32'h0000_0000);
        rd_chk(`DIO_ADR_PWM_FIRST, `DIO_RST_PWM);
        rd_chk(`DIO_ADR_PWM_SECOND, `DIO_RST_PWM);
        check_data();
        wr(`DIO_ADR_DIR, 32'h0000_FFFF, 4'hF);
        dir = 32'h0000_FFFF;
        wr(`DIO_ADR_POL, 32'h00FF_00FF, 4'hF);
        pol = 32'h00FF_00FF;
        wr(`DIO_ADR_DATA, 32'hA5A5_A5A5, 4'hF);
        lg = 32'hA5A5_A5A5 & dir;
        check_data();
        // only lane 2 turns to output: its stored logic must still be 0
        wr(`DIO_ADR_DIR, 32'hFFFF_FFFF, 4'b0100);
        dir = 32'h00FF_FFFF;
        check_data();
        mask(2'd0, 8'h3C, 8'hE7);
        mask(2'd1, 8'h4A, 8'h21);
        mask(2'd2, 8'hFF, 8'h00);
        mask(2'd3, 8'hFF, 8'h00);
        check_data();
        set_all(2'd0, 1'b1);
        set_all(2'd1, 1'b0);
        check_data();
        sense <= ~sense;
        repeat (4) @(posedge ref_clk);
        check_data();
        rd_chk(`DIO_ADR_PIN, (sense & ~dir) | ((lg ^ pol) & dir));
        wr(8'h3C, 32'hFFFF_FFFF, 4'hF);
        rd_chk(8'h3C, 32'h0000_0000);
        check_data();
        pwm(1, 4, 3, 5, 1'b0, 2'b11);
        pwm(0, 4, 7, 5, 1'b0, 2'b11);
        pwm(2, 4, 1, 4, 1'b1, 2'b11);
        pwm(3, 4, 3, 4, 1'b0, 2'b10);
        // ce low must hold the running generator at its last level
        ce <= 1'b0;
        repeat (2) @(posedge ref_clk);
        held = {31'h0, pulse_out_second};
        n_hi = 0;
        repeat (8)
        begin
            @(posedge ref_clk);
            n_hi += (pulse_out_second === 1'b1);
        end
        chk(32'(n_hi), held * 8, "frozen pwm");
        ce <= 1'b1;
        summarize();
    end
endmodule
